// *** bench/smc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module smc_host_model (
    output logic serial_clock,
    output logic serial_select_n,
    output logic serial_data_in,
    input wire logic serial_data_out
);
    initial
    begin
        serial_clock = 1'b0;
        serial_select_n = 1'b1;
        serial_data_in = 1'b0;
    end

    // nbits below 16 makes a short frame on purpose; odd offset keeps edges off the clock
    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        #3.3;
        serial_select_n = 1'b0;
        #62.5;
        for (int i = 15; i > 15 - nbits; i--)
        begin
            serial_clock = 1'b1;
            serial_data_in = tx[i];
            #62.5;
            rx[i] = serial_data_out;
            serial_clock = 1'b0;
            #62.5;
        end
        serial_select_n = 1'b1;
        // released line has no pull, so it shows the opposite of the last bit
        serial_data_in = ~serial_data_in;
        #100;
    endtask : xfer
endmodule : smc_host_model
`default_nettype wire

// *** bench/smc_mode_ctrl_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module smc_mode_ctrl_sva
    import smc_pkg::*;
#(
    parameter int unsigned SYS_RST_CYC = SYS_RST_CYC_DEF
)(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic bat_poweroff,
    input wire logic overtemp_flag,
    input wire logic wake_can,
    input wire logic wake_lin,
    input wire logic wake_local,
    input wire logic interrupt_line_low,
    input wire logic serial_clock,
    input wire logic serial_select_n,
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe,
    input wire smc_ctrl_s ctrl,
    input wire smc_mode_e mode
);
    default clocking @(posedge clock);
    endclocking
    // a frozen block makes no progress, so nothing is judged while the enable is low
    default disable iff (!rst_b || !clk_en);
    // levels are judged once mode has held for a cycle, as ctrl and mode register together
    a_off_on_poweroff:
        assert property ($rose(bat_poweroff) |-> ##[1:6] mode == SMC_OFF)
        else $error("power-off ignored");
    a_off_all_down:
        assert property ($stable(mode) && mode == SMC_OFF |-> !ctrl.mcu_regulator
            && !ctrl.can_regulator && ctrl.can_xcvr == XCVR_HIGHZ && !serial_data_out_oe)
        else $error("off mode not quiet");
    a_standby_entry_reset:
        assert property (mode == SMC_STANDBY && $past(mode) inside {SMC_OFF, SMC_SLEEP,
            SMC_OVERTEMP} |-> ctrl.system_reset_line_low [*4])
        else $error("standby entry without reset");
    a_sleep_entry_gate:
        assert property (mode == SMC_SLEEP && $past(mode) != SMC_SLEEP |-> interrupt_line_low
            && $past(mode) inside {SMC_STANDBY, SMC_NORMAL})
        else $error("bad sleep entry");
    a_sleep_levels:
        assert property ($stable(mode) && mode == SMC_SLEEP |-> !ctrl.mcu_regulator
            && !ctrl.can_regulator && ctrl.wd_mode == WD_OFF && ctrl.system_reset_line_low)
        else $error("sleep levels wrong");
    a_wake_exit:
        assert property (mode == SMC_SLEEP && (wake_can || wake_lin || wake_local)
            |-> ##[1:6] mode == SMC_STANDBY)
        else $error("wake ignored");
    a_overtemp_entry:
        assert property (overtemp_flag && !bat_poweroff && mode inside {SMC_STANDBY,
            SMC_NORMAL} |-> ##[1:6] mode == SMC_OVERTEMP)
        else $error("overtemperature ignored");
    a_overtemp_levels:
        assert property ($stable(mode) && mode == SMC_OVERTEMP |-> !ctrl.mcu_regulator
            && ctrl.lin_a_xcvr == XCVR_HIGHZ && ctrl.system_reset_line_low && ctrl.fallback_low)
        else $error("overtemp levels wrong");
    a_sdo_float:
        assert property (serial_select_n [*4] |-> !serial_data_out_oe)
        else $error("output driven while deselected");
    a_sdo_steady:
        assert property (!serial_select_n && $fell(serial_clock) |-> $stable(serial_data_out) [*4])
        else $error("output moved at sampling edge");
endmodule : smc_mode_ctrl_sva
bind smc_mode_ctrl smc_mode_ctrl_sva #(.SYS_RST_CYC(SYS_RST_CYC)) chk_u (.*);
`default_nettype wire

// *** bench/smc_mode_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module smc_mode_ctrl_tb_top;
    import smc_pkg::*;
    // short system reset keeps the run brief; the 3.6 ms short reset is never waited out
    localparam int unsigned RST_CYC = 20;
    localparam logic H = 1'b1;
    localparam logic L = 1'b0;
    localparam smc_xcvr_e OF = XCVR_OFF;
    localparam smc_xcvr_e LP = XCVR_LOWPOWER;
    localparam smc_xcvr_e AC = XCVR_ACTIVE;
    localparam smc_ctrl_s OFF_LVL = '{L, L, XCVR_HIGHZ, XCVR_HIGHZ, XCVR_HIGHZ, WD_OFF, H, L};
    logic clock, rst_b, bat_poweroff, bat_poweron, overtemp_flag, overtemp_release;
    logic clk_en;
    logic wake_can, wake_lin, wake_local, interrupt_line_low, watchdog_disable_pin;
    wire serial_clock, serial_select_n, serial_data_in, serial_data_out, serial_data_out_oe;
    smc_ctrl_s ctrl;
    smc_mode_e mode;
    logic [15:0] rx;
    int n_fail = 0;
    int checks = 0;

    smc_mode_ctrl #(.SYS_RST_CYC(RST_CYC)) dut_u (.*);
    smc_host_model host_u (.*);

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic give_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    task automatic wait_mode(input smc_mode_e m);
        int k;
        k = 0;
        while (mode !== m && k < 2000)
        begin
            @(negedge clock);
            k++;
        end
        cmp(mode, m);
        if (mode !== m)
            give_verdict();
    endtask : wait_mode

    task automatic wr(input logic [2:0] sel, input logic [11:0] d);
        host_u.xfer({sel, L, d}, 16, rx);
        @(negedge clock);
    endtask : wr

    // a read frame carries the inverse of the expected data, so a stray write shows up
    task automatic rd(input logic [2:0] sel, input logic [11:0] exp);
        host_u.xfer({sel, H, ~exp}, 16, rx);
        cmp(rx[11:0], exp);
        @(negedge clock);
    endtask : rd

    task automatic mc(input logic [11:0] d, input smc_mode_e m, input smc_ctrl_s c);
        wr(SEL_MODE_CTRL, d);
        wait_mode(m);
        repeat (3) @(negedge clock);
        cmp(ctrl, c);
    endtask : mc

    task automatic rst_pulse;
        cmp(ctrl.system_reset_line_low, H);
        repeat (RST_CYC + 6) @(negedge clock);
        cmp(ctrl.system_reset_line_low, L);
    endtask : rst_pulse

    initial
    begin
        rst_b = L;
        clk_en = H;
        {bat_poweroff, bat_poweron, overtemp_flag, overtemp_release} = 4'h0;
        {wake_can, wake_lin, wake_local, watchdog_disable_pin} = 4'h0;
        interrupt_line_low = H;
        repeat (12) @(negedge clock);
        cmp(ctrl, OFF_LVL);
        rst_b = H;
        repeat (6) @(negedge clock);
        cmp(mode, SMC_OFF);
        bat_poweron = H;
        wait_mode(SMC_STANDBY);
        rst_pulse();
        cmp(ctrl, smc_ctrl_s'{H, L, OF, OF, OF, WD_TIMEOUT, L, L});
        $display("done power-on");
        rd(SEL_WD_STATUS, WD_RST);
        rd(SEL_MODE_CTRL, MODE_RST);
        rd(SEL_INT_EN, INTEN_RST);
        rd(SEL_INT_STAT, INTST_RST);
        wr(SEL_INT_STAT, 12'h5a3);
        rd(SEL_INT_STAT, 12'h5a3);
        host_u.xfer({SEL_INT_STAT, L, 12'h0ff}, 15, rx);
        rd(SEL_INT_STAT, 12'h5a3);
        $display("done registers");
        mc(12'hd00, SMC_NORMAL, '{H, H, LP, AC, AC, WD_WINDOW, L, L});
        mc(12'h8c0, SMC_NORMAL, '{H, L, AC, LP, LP, WD_WINDOW, L, L});
        mc(12'h000, SMC_STANDBY, '{H, L, OF, OF, OF, WD_TIMEOUT, L, L});
        mc(12'h1c0, SMC_STANDBY, '{H, L, LP, LP, LP, WD_TIMEOUT, L, L});
        watchdog_disable_pin = H;
        rd(SEL_WD_STATUS, 12'h480);
        cmp(ctrl.wd_mode, WD_OFF);
        watchdog_disable_pin = L;
        wr(SEL_WD_STATUS, 12'hc00);
        mc(12'hc00, SMC_NORMAL, '{H, H, AC, AC, AC, WD_TIMEOUT, L, L});
        mc(12'h000, SMC_STANDBY, '{H, L, OF, OF, OF, WD_OFF, L, L});
        $display("done modes");
        wr(SEL_INT_EN, 12'h200);
        mc(12'h500, SMC_SLEEP, '{L, L, LP, OF, OF, WD_OFF, H, L});
        wake_local = H;
        wait_mode(SMC_STANDBY);
        wake_local = L;
        rst_pulse();
        cmp(ctrl.mcu_regulator, H);
        rd(SEL_MODE_CTRL, 12'h100);
        $display("done sleep");
        // a low enable must hold the mode even with overtemperature pending
        clk_en = L;
        overtemp_flag = H;
        repeat (10) @(negedge clock);
        cmp(mode, SMC_STANDBY);
        clk_en = H;
        wait_mode(SMC_OVERTEMP);
        repeat (3) @(negedge clock);
        cmp({ctrl[11:4], ctrl[1:0]}, 10'h0ff);
        overtemp_flag = L;
        overtemp_release = H;
        wait_mode(SMC_STANDBY);
        overtemp_release = L;
        rst_pulse();
        $display("done overtemp");
        interrupt_line_low = L;
        wr(SEL_MODE_CTRL, 12'h400);
        repeat (20) @(negedge clock);
        cmp(mode, SMC_STANDBY);
        cmp(ctrl.system_reset_line_low, H);
        bat_poweron = L;
        bat_poweroff = H;
        wait_mode(SMC_OFF);
        repeat (3) @(negedge clock);
        cmp({ctrl[11:1], serial_data_out_oe}, {OFF_LVL[11:1], L});
        bat_poweroff = L;
        bat_poweron = H;
        wait_mode(SMC_STANDBY);
        $display("done power-off");
        give_verdict();
    end
endmodule : smc_mode_ctrl_tb_top
`default_nettype wire

// *** include/smc_pkg.sv ***
package smc_pkg;

    localparam int unsigned CLK_HZ = 100_000_000;
    localparam real SHORT_RST_MS = 3.6;
    localparam int unsigned SHORT_RST_CYC = int'($ceil(SHORT_RST_MS * 1.0e-3 * CLK_HZ));
    localparam int unsigned SYS_RST_CYC_DEF = SHORT_RST_CYC;
    localparam int unsigned RST_CNT_W = 20;

    localparam int unsigned FRAME_W = 16;
    localparam int unsigned DATA_W = 12;
    localparam int unsigned BIT_CNT_W = 5;
    localparam int unsigned ADDR_HI = 15;
    localparam int unsigned ADDR_LO = 13;
    localparam int unsigned RO_POS = 12;

    localparam logic [2:0] SEL_WD_STATUS = 3'h0;
    localparam logic [2:0] SEL_MODE_CTRL = 3'h1;
    localparam logic [2:0] SEL_INT_EN = 3'h2;
    localparam logic [2:0] SEL_INT_STAT = 3'h3;

    // watchdog_status_reg field positions inside the 12 data bits
    localparam int unsigned WMC_POS = 11;
    localparam int unsigned WATCHDOG_DISABLE_PIN_POS = 7;
    // mode_control_reg fields
    localparam int unsigned MC_HI = 11;
    localparam int unsigned MC_LO = 10;
    localparam int unsigned LHC_POS = 9;
    localparam int unsigned CAN_XCVR_STANDBY_BIT_POS = 8;
    localparam int unsigned STBL1_POS = 7;
    localparam int unsigned STBL2_POS = 6;
    // interrupt_enable_reg: wake source enables
    localparam int unsigned WEN_CAN_POS = 11;
    localparam int unsigned WEN_LIN_POS = 10;
    localparam int unsigned WEN_LOC_POS = 9;

    localparam logic [1:0] MC_STANDBY = 2'h0;
    localparam logic [1:0] MC_SLEEP = 2'h1;
    localparam logic [1:0] MC_NORMAL_V2OFF = 2'h2;
    localparam logic [1:0] MC_NORMAL_V2ON = 2'h3;

    localparam logic [DATA_W-1:0] WD_RST = 12'h400;
    localparam logic [DATA_W-1:0] MODE_RST = 12'h000;
    localparam logic [DATA_W-1:0] INTEN_RST = 12'h000;
    localparam logic [DATA_W-1:0] INTST_RST = 12'h000;

    typedef enum logic [2:0] {
        SMC_OFF,
        SMC_STANDBY,
        SMC_NORMAL,
        SMC_SLEEP,
        SMC_OVERTEMP
    } smc_mode_e;

    typedef enum logic [1:0] {
        WD_OFF,
        WD_TIMEOUT,
        WD_WINDOW
    } smc_wd_e;

    typedef enum logic [1:0] {
        XCVR_OFF,
        XCVR_LOWPOWER,
        XCVR_ACTIVE,
        XCVR_HIGHZ
    } smc_xcvr_e;

    typedef struct packed {
        logic mcu_regulator;
        logic can_regulator;
        smc_xcvr_e can_xcvr;
        smc_xcvr_e lin_a_xcvr;
        smc_xcvr_e lin_b_xcvr;
        smc_wd_e wd_mode;
        logic system_reset_line_low;
        logic fallback_low;
    } smc_ctrl_s;

endpackage : smc_pkg

// *** rtl/smc_mode_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module smc_mode_ctrl
    import smc_pkg::*;
#(
    parameter int unsigned SYS_RST_CYC = SYS_RST_CYC_DEF
)(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic bat_poweroff,
    input wire logic bat_poweron,
    input wire logic overtemp_flag,
    input wire logic overtemp_release,
    input wire logic wake_can,
    input wire logic wake_lin,
    input wire logic wake_local,
    input wire logic interrupt_line_low,
    input wire logic watchdog_disable_pin,
    input wire logic serial_clock,
    input wire logic serial_select_n,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    output smc_ctrl_s ctrl,
    output smc_mode_e mode
);

    // all pins pass two flops; first stage is read only by the second
    localparam int unsigned NSYNC = 11;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync1_ff;
    logic [NSYNC-1:0] sync2_ff;
    assign async_in = {bat_poweroff, bat_poweron, overtemp_flag, overtemp_release,
                       wake_can, wake_lin, wake_local, interrupt_line_low,
                       watchdog_disable_pin, serial_clock, serial_select_n};
    logic sdi_s1_ff;
    logic sdi_s2_ff;

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++)
        begin : g_sync
            always_ff @(posedge clock or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    // reset to the idle level, so select shows no false edge after reset
                    sync1_ff[gi] <= (gi == 0);
                    sync2_ff[gi] <= (gi == 0);
                end
                else if (clk_en)
                begin
                    sync1_ff[gi] <= async_in[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                end
            end
        end
    endgenerate

    wire s_poweroff = sync2_ff[10];
    wire s_poweron = sync2_ff[9];
    wire s_ot = sync2_ff[8];
    wire s_ot_rel = sync2_ff[7];
    wire s_wake = sync2_ff[6] | sync2_ff[5] | sync2_ff[4];
    wire s_int_low = sync2_ff[3];
    wire s_watchdog_disable_pin = sync2_ff[2];
    wire s_sck = sync2_ff[1];
    wire s_csn = sync2_ff[0];

    logic sck_d_ff;
    logic csn_d_ff;
    logic [FRAME_W-1:0] rx_ff;
    logic [FRAME_W-1:0] tx_ff;
    logic [BIT_CNT_W-1:0] cnt_ff;
    logic sdo_ff;
    logic [DATA_W-1:0] wd_ff;
    logic [DATA_W-1:0] modec_ff;
    logic [DATA_W-1:0] inten_ff;
    logic [DATA_W-1:0] intst_ff;
    smc_mode_e mode_ff;
    smc_mode_e nxt_mode;
    logic [RST_CNT_W-1:0] rst_cnt_ff;
    logic [RST_CNT_W-1:0] nxt_rst_cnt;
    logic fallback_ff;
    logic nxt_fallback;
    logic mc_clr;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sdi_s1_ff <= 1'b0;
            sdi_s2_ff <= 1'b0;
            sck_d_ff <= 1'b0;
            csn_d_ff <= 1'b1;
        end
        else if (clk_en)
        begin
            sdi_s1_ff <= serial_data_in;
            sdi_s2_ff <= sdi_s1_ff;
            sck_d_ff <= s_sck;
            csn_d_ff <= s_csn;
        end
    end

    wire sck_fall = sck_d_ff & ~s_sck;
    wire sck_rise = ~sck_d_ff & s_sck;
    wire cs_fall = csn_d_ff & ~s_csn;
    wire cs_rise = ~csn_d_ff & s_csn;

    // readback: address bits, read-only flag as zero, then content
    // after four bits the header sits at the bottom of the shifter
    localparam int unsigned HDR_BITS = FRAME_W - RO_POS;
    wire [2:0] hdr_sel = rx_ff[HDR_BITS-1:HDR_BITS-1-(ADDR_HI-ADDR_LO)];
    wire [DATA_W-1:0] rd_wd = {wd_ff[DATA_W-1:WATCHDOG_DISABLE_PIN_POS+1], s_watchdog_disable_pin, wd_ff[WATCHDOG_DISABLE_PIN_POS-1:0]};
    wire [DATA_W-1:0] rd_data = (hdr_sel == SEL_WD_STATUS) ? rd_wd :
                                (hdr_sel == SEL_MODE_CTRL) ? modec_ff :
                                (hdr_sel == SEL_INT_EN) ? inten_ff :
                                (hdr_sel == SEL_INT_STAT) ? intst_ff : '0;
    wire [FRAME_W-1:0] tx_load = {hdr_sel, 1'b0, rd_data};
    wire frame_ok = cs_rise && (cnt_ff == BIT_CNT_W'(FRAME_W));
    wire [2:0] w_sel = rx_ff[ADDR_HI:ADDR_LO];
    wire w_ro = rx_ff[RO_POS];
    wire [DATA_W-1:0] w_data = rx_ff[DATA_W-1:0];
    wire do_write = frame_ok && !w_ro;

    // the header is only known after four bits, so the first four output bits
    // carry the previous frame's status word; the data part follows the address
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_ff <= '0;
            tx_ff <= '0;
            cnt_ff <= '0;
            sdo_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (cs_fall)
            begin
                cnt_ff <= '0;
                sdo_ff <= tx_ff[FRAME_W-1];
            end
            else if (!s_csn && sck_fall && cnt_ff < BIT_CNT_W'(FRAME_W))
            begin
                rx_ff <= {rx_ff[FRAME_W-2:0], sdi_s2_ff};
                cnt_ff <= cnt_ff + BIT_CNT_W'(1);
            end
            else if (!s_csn && sck_rise)
            begin
                sdo_ff <= tx_ff[FRAME_W-2];
                tx_ff <= {tx_ff[FRAME_W-2:0], 1'b0};
            end
            if (!s_csn && cnt_ff == BIT_CNT_W'(HDR_BITS) && !sck_fall && !sck_rise && !sck_d_ff)
            begin
                tx_ff <= {tx_load[DATA_W:0], 3'h0};
            end
            if (cs_rise)
            begin
                tx_ff <= {3'h0, 1'b0, wd_ff};
            end
        end
    end

    assign serial_data_out = sdo_ff;
    assign serial_data_out_oe = ~s_csn && (mode_ff != SMC_OFF) && (mode_ff != SMC_OVERTEMP);

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wd_ff <= WD_RST;
            modec_ff <= MODE_RST;
            inten_ff <= INTEN_RST;
            intst_ff <= INTST_RST;
        end
        else if (clk_en)
        begin
            if (mc_clr)
            begin
                modec_ff[MC_HI:MC_LO] <= MC_STANDBY;
            end
            else if (do_write && w_sel == SEL_MODE_CTRL)
            begin
                modec_ff <= w_data;
            end
            if (do_write && w_sel == SEL_WD_STATUS)
            begin
                wd_ff <= w_data;
            end
            if (do_write && w_sel == SEL_INT_EN)
            begin
                inten_ff <= w_data;
            end
            if (do_write && w_sel == SEL_INT_STAT)
            begin
                intst_ff <= w_data;
            end
        end
    end

    wire [1:0] mc_new = w_data[MC_HI:MC_LO];
    wire mc_wr = do_write && (w_sel == SEL_MODE_CTRL);
    wire wake_en = inten_ff[WEN_CAN_POS] | inten_ff[WEN_LIN_POS] | inten_ff[WEN_LOC_POS];
    wire sleep_ok = s_int_low && !s_wake && wake_en;
    wire rst_active = (rst_cnt_ff != '0);
    wire [RST_CNT_W-1:0] sys_rst_load = RST_CNT_W'(SYS_RST_CYC);
    wire [RST_CNT_W-1:0] short_rst_load = RST_CNT_W'(SHORT_RST_CYC);

    always_comb
    begin
        nxt_mode = mode_ff;
        nxt_rst_cnt = rst_active ? rst_cnt_ff - RST_CNT_W'(1) : rst_cnt_ff;
        nxt_fallback = fallback_ff;
        mc_clr = 1'b0;
        if (s_poweroff)
        begin
            nxt_mode = SMC_OFF;
            nxt_rst_cnt = '0;
        end
        else
        begin
            case (mode_ff)
                SMC_OFF:
                begin
                    if (s_poweron)
                    begin
                        nxt_mode = SMC_STANDBY;
                        nxt_rst_cnt = sys_rst_load;
                    end
                end
                SMC_STANDBY, SMC_NORMAL:
                begin
                    if (s_ot)
                    begin
                        nxt_mode = SMC_OVERTEMP;
                        nxt_fallback = 1'b1;
                    end
                    else if (mode_ff == SMC_NORMAL && rst_active)
                    begin
                        nxt_mode = SMC_STANDBY;
                        mc_clr = 1'b1;
                    end
                    else if (mc_wr && mc_new == MC_SLEEP)
                    begin
                        if (sleep_ok)
                        begin
                            nxt_mode = SMC_SLEEP;
                        end
                        else
                        begin
                            nxt_rst_cnt = short_rst_load;
                        end
                    end
                    else if (mc_wr && mode_ff == SMC_STANDBY &&
                             (mc_new == MC_NORMAL_V2OFF || mc_new == MC_NORMAL_V2ON))
                    begin
                        nxt_mode = SMC_NORMAL;
                    end
                    else if (mc_wr && mc_new == MC_STANDBY)
                    begin
                        nxt_mode = SMC_STANDBY;
                    end
                end
                SMC_SLEEP:
                begin
                    if (s_wake)
                    begin
                        nxt_mode = SMC_STANDBY;
                        nxt_rst_cnt = sys_rst_load;
                        mc_clr = 1'b1;
                    end
                end
                SMC_OVERTEMP:
                begin
                    if (s_ot_rel)
                    begin
                        nxt_mode = SMC_STANDBY;
                        nxt_rst_cnt = sys_rst_load;
                    end
                end
                default:
                begin
                    nxt_mode = SMC_OFF;
                end
            endcase
        end
    end

    // a reset in Normal clears the mode bits so a later read shows Standby
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_ff <= SMC_OFF;
            rst_cnt_ff <= '0;
            fallback_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            mode_ff <= nxt_mode;
            rst_cnt_ff <= nxt_rst_cnt;
            fallback_ff <= nxt_fallback;
        end
    end

    wire stb_can = modec_ff[CAN_XCVR_STANDBY_BIT_POS];
    wire stb_la = modec_ff[STBL1_POS];
    wire stb_lb = modec_ff[STBL2_POS];
    wire watchdog_mode_ctrl_bit = wd_ff[WMC_POS];
    wire v2_sel = (modec_ff[MC_HI:MC_LO] == MC_NORMAL_V2ON);

    function automatic smc_xcvr_e xc(input smc_mode_e m, input logic stb);
        case (m)
            SMC_NORMAL: xc = stb ? XCVR_LOWPOWER : XCVR_ACTIVE;
            SMC_STANDBY, SMC_SLEEP: xc = stb ? XCVR_LOWPOWER : XCVR_OFF;
            default: xc = XCVR_HIGHZ;
        endcase
    endfunction : xc

    smc_wd_e wd_mode;
    assign wd_mode = (s_watchdog_disable_pin) ? WD_OFF :
                     (mode_ff == SMC_NORMAL) ? (watchdog_mode_ctrl_bit ? WD_TIMEOUT : WD_WINDOW) :
                     (mode_ff == SMC_STANDBY) ? (watchdog_mode_ctrl_bit ? WD_OFF : WD_TIMEOUT) : WD_OFF;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl <= '{mcu_regulator: 1'b0, can_regulator: 1'b0, can_xcvr: XCVR_HIGHZ,
                      lin_a_xcvr: XCVR_HIGHZ, lin_b_xcvr: XCVR_HIGHZ, wd_mode: WD_OFF,
                      system_reset_line_low: 1'b1, fallback_low: 1'b0};
            mode <= SMC_OFF;
        end
        else if (clk_en)
        begin
            ctrl.mcu_regulator <= (mode_ff == SMC_STANDBY) || (mode_ff == SMC_NORMAL);
            ctrl.can_regulator <= (mode_ff == SMC_NORMAL) && v2_sel;
            ctrl.can_xcvr <= xc(mode_ff, stb_can);
            ctrl.lin_a_xcvr <= xc(mode_ff, stb_la);
            ctrl.lin_b_xcvr <= xc(mode_ff, stb_lb);
            ctrl.wd_mode <= wd_mode;
            ctrl.system_reset_line_low <= rst_active || (mode_ff == SMC_SLEEP) ||
                                          (mode_ff == SMC_OVERTEMP) || (mode_ff == SMC_OFF);
            ctrl.fallback_low <= fallback_ff;
            mode <= mode_ff;
        end
    end

endmodule : smc_mode_ctrl
`default_nettype wire
